// *** hw/mmp_map.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef MMP_MAP_SVH
`define MMP_MAP_SVH

`define MMP_OFS_CTRL0 8'h00
`define MMP_OFS_CTRL1 8'h04
`define MMP_OFS_RELOAD 8'h08
`define MMP_OFS_DEAD 8'h0c
`define MMP_OFS_DUTY0 8'h10
`define MMP_OFS_STATUS 8'h28

`define MMP_C0_RUN 0
`define MMP_C0_READY 1
`define MMP_C0_CENTER 2
`define MMP_C1_DIV_LSB 0
`define MMP_C1_REL_LSB 2
`define MMP_C1_INDEP 4

`define MMP_ST_DOWN 12
`define MMP_ST_FAULT 13
`define MMP_ST_OE 14
`define MMP_ST_OPT_LSB 16

`define MMP_RST_RELOAD 12'hfff
`define MMP_RST_DUTY 16'h0000
`define MMP_RST_DEAD 8'h00

`define MMP_CLK_PERIOD_NS 8
`define MMP_OE_SETTLE_NS 24
`define MMP_OE_SETTLE_CYC ((`MMP_OE_SETTLE_NS + `MMP_CLK_PERIOD_NS - 1) / `MMP_CLK_PERIOD_NS)

`endif

// *** hw/mmp_pkg.sv ***
// Types shared by the motor PWM modules.
`default_nettype none
package mmp_pkg;
   typedef enum logic [1:0] {
      MMP_PIN_HIZ,
      MMP_PIN_SETTLE,
      MMP_PIN_DRIVE
   } mmp_pin_state_t;
   typedef logic [1:0] mmp_sel2_t;
   typedef logic [7:0] mmp_addr_t;
   typedef logic [31:0] mmp_word_t;
endpackage : mmp_pkg
`default_nettype wire

// *** hw/mmp_prescale.sv ***
// Counter-clock tick generator dividing the system clock by 1, 2, 4 or 8.
`default_nettype none
module mmp_prescale (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire mmp_pkg::mmp_sel2_t div_sel_i,
   output logic tick_o
);
   import mmp_pkg::*;

   logic [2:0] pcnt_r;
   logic [2:0] pcnt_nxt;
   wire [3:0] lim_w = (4'h1 << div_sel_i) - 4'h1;
   // Compare with >= so a smaller divide taken mid-count cannot run away.
   wire hit_w = pcnt_r >= lim_w[2:0];

   assign tick_o = run_i & hit_w;
   assign pcnt_nxt = (!run_i || hit_w) ? 3'h0 : pcnt_r + 3'h1;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pcnt_r <= 3'h0;
      end else begin
         pcnt_r <= pcnt_nxt;
      end
   end
endmodule : mmp_prescale
`default_nettype wire

// *** hw/mmp_deadband.sv ***
// One high/low output pair with optional complementary dead-time insertion.
`default_nettype none
module mmp_deadband #(
   parameter int DEAD_W = 8
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic comp_i,
   input wire logic hi_dem_i,
   input wire logic lo_dem_i,
   input wire logic [DEAD_W-1:0] dead_i,
   output logic act_h_o,
   output logic act_l_o
);
   import mmp_pkg::*;

   logic prev_r;
   logic [DEAD_W-1:0] dcnt_r;
   logic [DEAD_W-1:0] dcnt_nxt;
   wire chg_w = hi_dem_i != prev_r;
   wire settled_w = dcnt_nxt == '0;

   // A change mid-gap restarts the gap, so neither side is ever on early.
   assign dcnt_nxt = chg_w ? dead_i :
                     (dcnt_r != '0) ? dcnt_r - DEAD_W'(1) : '0;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prev_r <= 1'b0;
         dcnt_r <= '0;
         act_h_o <= 1'b0;
         act_l_o <= 1'b0;
      end else if (comp_i) begin
         prev_r <= hi_dem_i;
         dcnt_r <= dcnt_nxt;
         act_h_o <= settled_w & hi_dem_i;
         act_l_o <= settled_w & ~hi_dem_i;
      end else begin
         prev_r <= hi_dem_i;
         dcnt_r <= '0;
         act_h_o <= hi_dem_i;
         act_l_o <= lo_dem_i;
      end
   end
endmodule : mmp_deadband
`default_nettype wire

// *** hw/mmp_top.sv ***
// Six-output motor PWM generator with buffered timing registers.
`include "mmp_map.svh"
`default_nettype none
// Contract
// - High-side off level equals its option bit
// - Low-side option sets low-side off level
// - Option bits are pins, never software-writable
// - Option off: all PWM pins stay undriven
// - Option on: undriven, then off-state after reset; low sides drive active instead, pairs reset complementary with no demand
// - System reset drives outputs to off-state
// - Duty and divide double-buffered until reload
// - Reload every 1, 2, 4 or 8 periods
// - Ready bit arms transfer at next reload
// - Divide system clock by 1, 2, 4, 8
// - Edge mode: count up, wrap to zero
// - Center mode: count up then down
// - Signed 16-bit duty against unsigned count
// - Duty zero or negative: never asserted
// - Duty above reload: asserted whole period
// - Three pairs, independent or complementary
// - Dead time keeps pair never both active
// - Fault forces off-state without a clock
// - Dead time 0..255 system clocks, both off
// - Independent bit; else high duties drive pairs
module mmp_top #(
   parameter int CNT_W = 12,
   parameter int DUTY_W = 16,
   parameter int DEAD_W = 8
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire mmp_pkg::mmp_addr_t addr_i,
   input wire mmp_pkg::mmp_word_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output mmp_pkg::mmp_word_t rdata_o,
   input wire logic high_side_offstate_option_i,
   input wire logic low_side_offstate_option_i,
   input wire logic motor_output_enable_option_i,
   input wire logic fault_n_i,
   output logic [2:0] high_side_out_o,
   output logic [2:0] low_side_out_o,
   output logic [2:0] high_side_oe_o,
   output logic [2:0] low_side_oe_o,
   output logic reload_event_o
);
   import mmp_pkg::*;

   if (CNT_W < 2 || CNT_W > 15 || DUTY_W <= CNT_W || DUTY_W > 32 ||
       DEAD_W < 1 || DEAD_W > 16) begin : g_bad_width
      $error("mmp_top: unsupported counter, duty or dead-time width");
   end

   localparam int NCH = 6;

   // Option straps are static but still cross in through two flops.
   logic [2:0] opt_meta_r;
   logic [2:0] opt_sync_r;
   logic fault_meta_r;
   logic fault_sync_r;

   always_ff @(posedge mclk_i) begin
      opt_meta_r <= {motor_output_enable_option_i,
                     low_side_offstate_option_i,
                     high_side_offstate_option_i};
      opt_sync_r <= opt_meta_r;
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         fault_meta_r <= 1'b1;
         fault_sync_r <= 1'b1;
      end else begin
         fault_meta_r <= fault_n_i;
         fault_sync_r <= fault_meta_r;
      end
   end

   wire hi_off_w = opt_sync_r[0];
   wire lo_off_w = opt_sync_r[1];
   wire mc_en_w = opt_sync_r[2];

   // Software-visible state: shadow copies and direct controls.
   logic run_r;
   logic ready_r;
   logic center_sh_r;
   logic [1:0] div_sh_r;
   logic [1:0] relint_r;
   logic indep_r;
   logic [CNT_W-1:0] reload_sh_r;
   logic [DEAD_W-1:0] dead_r;
   logic [DUTY_W-1:0] duty_sh_r [NCH];

   // Active copies steering the counter and compare logic.
   logic center_act_r;
   logic [1:0] div_act_r;
   logic [CNT_W-1:0] reload_act_r;
   logic [DUTY_W-1:0] duty_act_r [NCH];

   // Address decode.
   wire hit_c0_w = addr_i == `MMP_OFS_CTRL0;
   wire hit_c1_w = addr_i == `MMP_OFS_CTRL1;
   wire hit_rel_w = addr_i == `MMP_OFS_RELOAD;
   wire hit_dead_w = addr_i == `MMP_OFS_DEAD;
   wire hit_st_w = addr_i == `MMP_OFS_STATUS;
   logic [NCH-1:0] hit_duty_w;

   wire wr_c0_w = wr_i & hit_c0_w;
   wire wr_c1_w = wr_i & hit_c1_w;
   wire wr_rel_w = wr_i & hit_rel_w;
   wire wr_dead_w = wr_i & hit_dead_w;
   wire ready_set_w = wr_c0_w & wdata_i[`MMP_C0_READY];

   // Counter and reload-event logic.
   logic tick_w;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic down_r;
   logic down_nxt;
   logic period_end_w;
   logic [2:0] per_cnt_r;
   wire [3:0] per_lim4_w = (4'h1 << relint_r) - 4'h1;
   wire [2:0] per_lim_w = per_lim4_w[2:0];
   wire per_last_w = per_cnt_r >= per_lim_w;
   // While stopped the transfer happens at once so the first period is sane.
   wire reload_ev_w = run_r ? (period_end_w & per_last_w) : 1'b1;
   wire xfer_w = reload_ev_w & ready_r;
   wire [CNT_W:0] cnt_inc_w = {1'b0, cnt_r} + {{CNT_W{1'b0}}, 1'b1};
   wire edge_wrap_w = cnt_inc_w >= {1'b0, reload_act_r};
   wire peak_w = cnt_r >= reload_act_r;
   wire low_reload_w = reload_act_r <= CNT_W'(1);
   wire bottom_w = cnt_r <= CNT_W'(1);

   assign reload_event_o = run_r & reload_ev_w;

   mmp_prescale u_prescale (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .run_i(run_r),
      .div_sel_i(div_act_r),
      .tick_o(tick_w)
   );

   always_comb begin
      cnt_nxt = cnt_r;
      down_nxt = down_r;
      period_end_w = 1'b0;
      if (!run_r) begin
         cnt_nxt = '0;
         down_nxt = 1'b0;
      end else if (!tick_w) begin
         cnt_nxt = cnt_r;
      end else if (!center_act_r) begin
         if (edge_wrap_w) begin
            cnt_nxt = '0;
            period_end_w = 1'b1;
         end else begin
            cnt_nxt = cnt_inc_w[CNT_W-1:0];
         end
      end else if (!down_r) begin
         if (peak_w && low_reload_w) begin
            cnt_nxt = '0;
            period_end_w = 1'b1;
         end else if (peak_w) begin
            cnt_nxt = cnt_r - CNT_W'(1);
            down_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_inc_w[CNT_W-1:0];
         end
      end else if (bottom_w) begin
         cnt_nxt = '0;
         down_nxt = 1'b0;
         period_end_w = 1'b1;
      end else begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         down_r <= 1'b0;
         per_cnt_r <= 3'h0;
      end else begin
         cnt_r <= cnt_nxt;
         down_r <= down_nxt;
         if (!run_r) begin
            per_cnt_r <= 3'h0;
         end else if (period_end_w) begin
            per_cnt_r <= per_last_w ? 3'h0 : per_cnt_r + 3'h1;
         end
      end
   end

   // Control registers; a ready write beside a transfer keeps ready set.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         run_r <= 1'b0;
         ready_r <= 1'b0;
         center_sh_r <= 1'b0;
         div_sh_r <= 2'h0;
         relint_r <= 2'h0;
         indep_r <= 1'b0;
         reload_sh_r <= CNT_W'(`MMP_RST_RELOAD);
         dead_r <= DEAD_W'(`MMP_RST_DEAD);
      end else begin
         if (ready_set_w) begin
            ready_r <= 1'b1;
         end else if (xfer_w) begin
            ready_r <= 1'b0;
         end
         if (wr_c0_w) begin
            run_r <= wdata_i[`MMP_C0_RUN];
            center_sh_r <= wdata_i[`MMP_C0_CENTER];
         end
         if (wr_c1_w) begin
            div_sh_r <= wdata_i[`MMP_C1_DIV_LSB +: 2];
            relint_r <= wdata_i[`MMP_C1_REL_LSB +: 2];
            indep_r <= wdata_i[`MMP_C1_INDEP];
         end
         if (wr_rel_w) begin
            reload_sh_r <= wdata_i[CNT_W-1:0];
         end
         if (wr_dead_w) begin
            dead_r <= wdata_i[DEAD_W-1:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         center_act_r <= 1'b0;
         div_act_r <= 2'h0;
         reload_act_r <= CNT_W'(`MMP_RST_RELOAD);
      end else if (xfer_w) begin
         center_act_r <= center_sh_r;
         div_act_r <= div_sh_r;
         reload_act_r <= reload_sh_r;
      end
   end

   // Per-channel duty shadow, active copy and compare.
   logic [NCH-1:0] demand_w;
   logic [DUTY_W-1:0] duty_rd_w [NCH];
   wire [DUTY_W-1:0] cnt_ext_w = DUTY_W'(cnt_r);

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      assign hit_duty_w[i] = addr_i == 8'(`MMP_OFS_DUTY0 + 4 * i);
      assign duty_rd_w[i] = {DUTY_W{hit_duty_w[i]}} & duty_sh_r[i];
      // The sign bit and a zero value both suppress the pulse entirely.
      assign demand_w[i] = run_r & ~duty_act_r[i][DUTY_W-1] &
                           (duty_act_r[i] != '0) &
                           (cnt_ext_w < duty_act_r[i]);
      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            duty_sh_r[i] <= DUTY_W'(`MMP_RST_DUTY);
            duty_act_r[i] <= DUTY_W'(`MMP_RST_DUTY);
         end else begin
            if (wr_i && hit_duty_w[i]) begin
               duty_sh_r[i] <= wdata_i[DUTY_W-1:0];
            end
            if (xfer_w) begin
               duty_act_r[i] <= duty_sh_r[i];
            end
         end
      end
   end

   // Pairs: channel 2p is the high side, 2p+1 the low side.
   logic [2:0] act_h_w;
   logic [2:0] act_l_w;

   for (genvar p = 0; p < 3; p++) begin : g_pair
      mmp_deadband #(
         .DEAD_W(DEAD_W)
      ) u_dead (
         .mclk_i(mclk_i),
         .rst_i(rst_i),
         .comp_i(~indep_r),
         .hi_dem_i(demand_w[2*p]),
         .lo_dem_i(demand_w[2*p+1]),
         .dead_i(dead_r),
         .act_h_o(act_h_w[p]),
         .act_l_o(act_l_w[p])
      );
   end

   // The fault pin bypasses every flop so a stopped clock cannot delay it.
   wire [2:0] gate_h_w = act_h_w & {3{fault_n_i}};
   wire [2:0] gate_l_w = act_l_w & {3{fault_n_i}};
   assign high_side_out_o = gate_h_w ^ {3{hi_off_w}};
   assign low_side_out_o = gate_l_w ^ {3{lo_off_w}};

   // Pin drive waits out reset, one idle cycle, then the MMP_OE_SETTLE_CYC settle count.
   localparam int SETTLE_CYC = `MMP_OE_SETTLE_CYC;
   mmp_pin_state_t pin_st_r;
   mmp_pin_state_t pin_st_nxt;
   logic [3:0] settle_r;
   wire settle_done_w = settle_r >= 4'(SETTLE_CYC - 1);

   always_comb begin
      pin_st_nxt = pin_st_r;
      case (pin_st_r)
         MMP_PIN_HIZ: pin_st_nxt = MMP_PIN_SETTLE;
         MMP_PIN_SETTLE: begin
            if (settle_done_w) begin
               pin_st_nxt = MMP_PIN_DRIVE;
            end
         end
         MMP_PIN_DRIVE: pin_st_nxt = MMP_PIN_DRIVE;
         default: pin_st_nxt = MMP_PIN_HIZ;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pin_st_r <= MMP_PIN_HIZ;
         settle_r <= 4'h0;
      end else begin
         pin_st_r <= pin_st_nxt;
         if (pin_st_r == MMP_PIN_SETTLE && !settle_done_w) begin
            settle_r <= settle_r + 4'h1;
         end
      end
   end

   wire oe_w = (pin_st_r == MMP_PIN_DRIVE) & mc_en_w;
   assign high_side_oe_o = {3{oe_w}};
   assign low_side_oe_o = {3{oe_w}};

   // Read path: data stand only in the cycle after the strobe.
   logic [DUTY_W-1:0] duty_any_w;
   always_comb begin
      duty_any_w = '0;
      for (int k = 0; k < NCH; k++) begin
         duty_any_w = duty_any_w | duty_rd_w[k];
      end
   end

   wire [31:0] c0_rd_w = {29'h0, center_sh_r, ready_r, run_r};
   wire [31:0] c1_rd_w = {27'h0, indep_r, relint_r, div_sh_r};
   wire [31:0] rel_rd_w = 32'(reload_sh_r);
   wire [31:0] dead_rd_w = 32'(dead_r);
   wire [31:0] duty_rd32_w = 32'(duty_any_w);
   wire [31:0] st_rd_w = {13'h0, mc_en_w, lo_off_w, hi_off_w, 1'b0, oe_w,
                          ~fault_sync_r, down_r, 12'(cnt_r)};
   wire [31:0] rd_mux_w = hit_c0_w ? c0_rd_w :
                          hit_c1_w ? c1_rd_w :
                          hit_rel_w ? rel_rd_w :
                          hit_dead_w ? dead_rd_w :
                          hit_st_w ? st_rd_w :
                          (|hit_duty_w) ? duty_rd32_w : 32'h0000_0000;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         rdata_o <= rd_i ? rd_mux_w : 32'h0000_0000;
      end
   end
endmodule : mmp_top
`default_nettype wire

// *** test/mmp_gate_drv.sv ***
// Gate-driver model that sits on the six PWM pins.
`default_nettype none
module mmp_gate_drv (
   input wire logic [2:0] hi_pin_i,
   input wire logic [2:0] lo_pin_i,
   input wire logic [2:0] hi_oe_i,
   input wire logic [2:0] lo_oe_i,
   input wire logic hi_off_i,
   input wire logic lo_off_i,
   output logic [2:0] hi_on_o,
   output logic [2:0] lo_on_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Driver inputs carry pull-downs, so a released pin reads low, never X.
   wire logic [2:0] hi_wire = hi_pin_i & hi_oe_i;
   wire logic [2:0] lo_wire = lo_pin_i & lo_oe_i;
   // A switch conducts only when its wire leaves the strapped off level.
   assign hi_on_o = hi_oe_i & (hi_wire ^ {3{hi_off_i}});
   assign lo_on_o = lo_oe_i & (lo_wire ^ {3{lo_off_i}});
endmodule : mmp_gate_drv
`default_nettype wire

// *** test/mmp_top_checker.sv ***
// Port-level assertions for the motor PWM top.
`include "mmp_map.svh"
`default_nettype none
module mmp_checker (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire mmp_pkg::mmp_addr_t addr_i,
   input wire mmp_pkg::mmp_word_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire mmp_pkg::mmp_word_t rdata_o,
   input wire logic high_side_offstate_option_i,
   input wire logic low_side_offstate_option_i,
   input wire logic motor_output_enable_option_i,
   input wire logic fault_n_i,
   input wire logic [2:0] high_side_out_o,
   input wire logic [2:0] low_side_out_o,
   input wire logic [2:0] high_side_oe_o,
   input wire logic [2:0] low_side_oe_o,
   input wire logic reload_event_o
);
   import mmp_pkg::*;
   logic indep_r;
   wire logic mot = motor_output_enable_option_i;
   wire logic [2:0] ah = high_side_out_o ^ {3{high_side_offstate_option_i}};
   wire logic [2:0] al = low_side_out_o ^ {3{low_side_offstate_option_i}};
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         indep_r <= 1'b0;
      else if (wr_i && addr_i == `MMP_OFS_CTRL1)
         indep_r <= wdata_i[`MMP_C1_INDEP];
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   sequence oe_off_s;
      high_side_oe_o == 3'b000 && low_side_oe_o == 3'b000;
   endsequence
   sequence oe_on_s;
      high_side_oe_o == 3'b111 && low_side_oe_o == 3'b111;
   endsequence
   fault_high_a: assert property (!fault_n_i |->
      high_side_out_o == {3{$past(high_side_offstate_option_i, 2)}})
      else $error("high side not off during fault");
   fault_low_a: assert property (!fault_n_i |->
      low_side_out_o == {3{$past(low_side_offstate_option_i, 2)}})
      else $error("low side not off during fault");
   oe_idle_a: assert property (!mot && !$past(mot) && !$past(mot, 2)
      |-> oe_off_s) else $error("pins driven with option off");
   oe_start_a: assert property ($fell(rst_i) && mot && $past(mot, 2)
      |-> oe_off_s ##[1:6] oe_on_s) else $error("pin drive start wrong");
   no_overlap_a: assert property (!indep_r && !$past(indep_r)
      && !$past(indep_r, 2) |-> (ah & al) == 3'b000)
      else $error("pair active on both sides");
   rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == '0)
      else $error("read data outside its cycle");
   unmapped_read_a: assert property ($past(rd_i) && $past(addr_i) > 8'h28
      |-> rdata_o == '0) else $error("unmapped read not zero");
   opt_read_a: assert property ($past(rd_i) && $past(addr_i) == 8'h28
      |-> rdata_o[18:16] == {$past(mot, 3),
      $past(low_side_offstate_option_i, 3),
      $past(high_side_offstate_option_i, 3)})
      else $error("option bits misreported");
endmodule : mmp_checker
bind mmp_top mmp_checker chk_u (.mclk_i(mclk_i), .rst_i(rst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o),
   .high_side_offstate_option_i(high_side_offstate_option_i),
   .low_side_offstate_option_i(low_side_offstate_option_i),
   .motor_output_enable_option_i(motor_output_enable_option_i),
   .fault_n_i(fault_n_i), .high_side_out_o(high_side_out_o),
   .low_side_out_o(low_side_out_o), .high_side_oe_o(high_side_oe_o),
   .low_side_oe_o(low_side_oe_o), .reload_event_o(reload_event_o));
`default_nettype wire

// *** test/multichannel_motor_pwm_tb.sv ***
// Self-checking bench for the six-output motor PWM top.
`include "mmp_map.svh"
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   fails++; $display("[ERR] %s exp %0d got %0d", n, e, g); end end
module multichannel_motor_pwm_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mmp_pkg::*;
   localparam int R = 10;
   logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, fault_n_i = 1;
   logic hopt = 1, lopt = 0, mopt = 1, rel;
   mmp_addr_t addr_i = '0;
   mmp_word_t wdata_i = '0, rdata_o, v;
   logic [2:0] hs, ls, hoe, loe, hon, lon;
   logic [31:0] rnd = 32'hc5c5_df95;
   int fails = 0, num_checks = 0, g, h, eh, el, c[6], d[6];
   mmp_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .high_side_offstate_option_i(hopt), .low_side_offstate_option_i(lopt),
      .motor_output_enable_option_i(mopt), .fault_n_i(fault_n_i),
      .high_side_out_o(hs), .low_side_out_o(ls), .high_side_oe_o(hoe),
      .low_side_oe_o(loe), .reload_event_o(rel));
   mmp_gate_drv gd_u (.hi_pin_i(hs), .lo_pin_i(ls), .hi_oe_i(hoe),
      .lo_oe_i(loe), .hi_off_i(hopt), .lo_off_i(lopt), .hi_on_o(hon),
      .lo_on_o(lon));
   initial forever #4 mclk_i = ~mclk_i;
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : nx
   function automatic int clip(input int x);
      return x <= 0 ? 0 : (x > R ? R : x);
   endfunction : clip
   function automatic int cact(input int x);
      return x <= 0 ? 0 : (x > R ? 2 * R : 2 * x - 1);
   endfunction : cact
   task automatic tick();
      @(posedge mclk_i);
      #1;
   endtask : tick
   task automatic wr(input mmp_addr_t a, input mmp_word_t w);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= w;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input mmp_addr_t a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      v = rdata_o;
   endtask : rd
   // The ready write carries c0r; run and mode follow in c0 afterwards.
   task automatic cfg(input mmp_word_t c1, c0r, c0);
      int i;
      wr(`MMP_OFS_CTRL1, c1);
      wr(`MMP_OFS_CTRL0, c0r | 32'h0000_0002);
      v = 32'h0000_0002;
      for (i = 0; v[1] !== 1'b0 && i < 3000; i++)
         rd(`MMP_OFS_CTRL0);
      `CHK("ready", 1'b0, v[1])
      wr(`MMP_OFS_CTRL0, c0);
   endtask : cfg
   task automatic gap();
      int n;
      tick();
      for (n = 0; rel !== 1'b1 && n < 5000; n++)
         tick();
      g = 0;
      do begin
         tick();
         g++;
      end while (rel !== 1'b1 && g < 5000);
   endtask : gap
   task automatic cnt(input int n);
      c = '{default: 0};
      repeat (n) begin
         tick();
         for (int p = 0; p < 3; p++) begin
            c[2 * p] += int'(hon[p]);
            c[2 * p + 1] += int'(lon[p]);
         end
      end
   endtask : cnt
   task automatic setd();
      for (int k = 0; k < 6; k++)
         wr(`MMP_OFS_DUTY0 + 8'(4 * k), 32'(d[k]));
   endtask : setd
   task automatic rst_run(input logic hv, lv, mv);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      hopt <= hv;
      lopt <= lv;
      mopt <= mv;
      repeat (16) @(posedge mclk_i);
      #1;
      `CHK("rst hi", {3{hv}}, hs)
      `CHK("rst lo", {3{lv}}, ls)
      `CHK("rst oe", 3'b000, hoe)
      @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (8) tick();
      `CHK("oe hi", {3{mv}}, hoe)
      `CHK("oe lo", {3{mv}}, loe)
      $display("test reset done");
   endtask : rst_run
   task automatic run_ind();
      rnd = nx(rnd);
      d = '{4, R, 0, -5, R + 1, int'(rnd[3:0]) - 3};
      setd();
      wr(`MMP_OFS_RELOAD, 32'(R));
      cfg(32'h0000_0010, 32'h0000_0000, 32'h0000_0001);
      gap();
      `CHK("edge period", R, g)
      cnt(4 * R);
      for (int k = 0; k < 6; k++)
         `CHK("ind", 4 * clip(d[k]), c[k])
      $display("test independent done");
   endtask : run_ind
   task automatic end_sim();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   initial begin
      #(8 * 40000);
      fails++;
      end_sim();
   end
   initial begin
      rst_run(1'b1, 1'b0, 1'b1);
      rd(`MMP_OFS_RELOAD);
      `CHK("reload rst", 32'h0000_0fff, v)
      wr(8'h2c, rnd);
      rd(8'h2c);
      `CHK("unmapped", 32'h0000_0000, v)
      wr(`MMP_OFS_STATUS, 32'hffff_ffff);
      rd(`MMP_OFS_STATUS);
      `CHK("options", 3'b101, v[18:16])
      for (int k = 0; k < 6; k++) begin
         rnd = nx(rnd);
         wr(`MMP_OFS_DUTY0 + 8'(4 * k), rnd);
         rd(`MMP_OFS_DUTY0 + 8'(4 * k));
         `CHK("duty rb", {16'h0000, rnd[15:0]}, v)
      end
      $display("test registers done");
      run_ind();
      d[0] = 7;
      wr(`MMP_OFS_DUTY0, 32'h0000_0007);
      cnt(4 * R);
      `CHK("shadow", 4 * 4, c[0])
      cfg(32'h0000_0010, 32'h0000_0001, 32'h0000_0001);
      cnt(4 * R);
      `CHK("loaded", 4 * 7, c[0])
      for (int k = 1; k < 4; k++) begin
         wr(`MMP_OFS_CTRL1, 32'(k * 5) | 32'h0000_0010);
         gap();
         gap();
         `CHK("old div", (R << (k - 1)) << k, g)
         cfg(32'(k * 5) | 32'h0000_0010, 32'h0000_0001, 32'h0000_0001);
         gap();
         `CHK("new div", R << (2 * k), g)
      end
      $display("test reload done");
      cfg(32'h0000_0010, 32'h0000_0004, 32'h0000_0005);
      gap();
      `CHK("center period", 2 * R, g)
      cnt(8 * R);
      for (int k = 0; k < 6; k++)
         `CHK("center", 4 * cact(d[k]), c[k])
      $display("test center done");
      wr(`MMP_OFS_CTRL0, 32'h0000_0000);
      repeat (4) tick();
      d[0] = 5;
      setd();
      for (int n = 0; n < 5; n += 2) begin
         wr(`MMP_OFS_DEAD, 32'(n));
         cfg(32'h0000_0000, 32'h0000_0000, 32'h0000_0001);
         // An always-on pair loses one dead gap at start; count after it.
         repeat (R) tick();
         cnt(4 * R);
         for (int p = 0; p < 3; p++) begin
            h = clip(d[2 * p]);
            eh = (h == 0 || h == R) ? h : h - n;
            el = (h == 0 || h == R) ? R - h : R - h - n;
            `CHK("comp hi", 4 * eh, c[2 * p])
            `CHK("comp lo", 4 * el, c[2 * p + 1])
         end
      end
      $display("test complementary done");
      @(posedge mclk_i);
      fault_n_i <= 1'b0;
      #1;
      `CHK("fault hi", {3{hopt}}, hs)
      `CHK("fault lo", {3{lopt}}, ls)
      @(posedge mclk_i);
      fault_n_i <= 1'b1;
      $display("test fault done");
      rst_run(1'b0, 1'b1, 1'b1);
      run_ind();
      rst_run(1'b1, 1'b1, 1'b0);
      end_sim();
   end
endmodule : multichannel_motor_pwm_tb
`default_nettype wire
